// ===== logic/hcd_params.svh
// Constants for the pseudo-ternary line codec.
`ifndef HCD_PARAMS_SVH
`define HCD_PARAMS_SVH

// Encoder look-ahead stages between capture and symbol decision.
`define HCD_ENC_STAGES 3
// Decoder stages between rail sampling and the NRZ output register.
`define HCD_DEC_STAGES 3
// Width of the same-polarity mark run counter.
`define HCD_RUN_W 2
// Run length reached at the second equal mark; the third is an error.
`define HCD_RUN_ERR 2'h2
// Run length after a mark of new polarity.
`define HCD_RUN_ONE 2'h1
// Symbol buffer geometry.
`define HCD_BUF_W 2
`define HCD_BUF_DEPTH 2

`endif

// ===== logic/hcd_pkg.sv
// Types shared by the line codec files.
package hcd_pkg;

    // Marks a zero already claimed by a substitution pattern.
    typedef enum logic [1:0] {
        HCD_FL_NONE = 2'h0,
        HCD_FL_SUB  = 2'h1,
        HCD_FL_VIOL = 2'h3
    } hcd_flag_t;

    // One line symbol: both low is a space, one high is a mark.
    typedef struct packed {
        logic pos;
        logic neg;
    } hcd_sym_t;

endpackage

// ===== logic/hcd_skid_buf.sv
// Small valid/ready buffer for line symbols.
`include "hcd_params.svh"
module hcd_skid_buf #(
    parameter int W     = `HCD_BUF_W,
    parameter int DEPTH = `HCD_BUF_DEPTH
) (
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic          push;
    logic          pop;

    assign in_ready_out  = (cnt_q != CW'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rd_q];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_q + 1'b1);
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_q + 1'b1);
            end
            cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
        end
    end
endmodule

// ===== logic/hcd_line_codec.sv
// HDB3 / AMI line encoder and decoder, both clocks sampled on the system clock.
`include "hcd_params.svh"
module hcd_line_codec (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic code_select_in,
    input  wire logic enc_clk_in,
    input  wire logic nrz_data_in,
    output logic      tx_pos_rail_out,
    output logic      tx_neg_rail_out,
    input  wire logic dec_clk_in,
    input  wire logic rx_pos_rail_in,
    input  wire logic rx_neg_rail_in,
    output logic      nrz_data_out,
    output logic      error_out
);
    localparam int ES = `HCD_ENC_STAGES;
    localparam int DS = `HCD_DEC_STAGES;

    // Mode is the only state both directions see.
    logic hdb3_q;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hdb3_q <= 1'b0;
        end else begin
            hdb3_q <= code_select_in;
        end
    end

    // Encoder.
    logic                enc_now_q;
    logic                enc_old_q;
    logic                nrz_q;
    logic                enc_rise;
    logic                enc_fall;
    logic [ES-1:0]       bit_q;
    hcd_pkg::hcd_flag_t  flag_q [ES];
    logic                last_pos_q;
    logic                odd_q;
    logic                sub;
    logic                lead_bit;
    hcd_pkg::hcd_flag_t  lead_flag;
    hcd_pkg::hcd_sym_t   sym_d;
    hcd_pkg::hcd_sym_t   sym_buf;
    logic                buf_ready;
    logic                buf_valid;
    logic                enc_step;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            enc_now_q <= 1'b0;
            enc_old_q <= 1'b0;
            nrz_q     <= 1'b0;
        end else begin
            enc_now_q <= enc_clk_in;
            enc_old_q <= enc_now_q;
            nrz_q     <= nrz_data_in;
        end
    end

    assign enc_rise  = enc_now_q & ~enc_old_q;
    assign enc_fall  = ~enc_now_q & enc_old_q;
    assign lead_bit  = bit_q[ES-1];
    assign lead_flag = flag_q[ES-1];
    // Back-pressure: a full buffer holds the pipeline rather than overwrite a symbol.
    assign enc_step  = enc_fall & buf_ready;

    // A run of four zeros is seen when the leaving zero has three zeros behind it.
    assign sub = hdb3_q & ~lead_bit & (lead_flag == hcd_pkg::HCD_FL_NONE)
               & (bit_q[ES-2:0] == '0) & ~nrz_q;

    always_comb begin
        sym_d = '0;
        if (lead_flag == hcd_pkg::HCD_FL_VIOL) begin
            sym_d.pos = last_pos_q;
            sym_d.neg = ~last_pos_q;
        end else if (lead_bit | (sub & ~odd_q)) begin
            sym_d.pos = ~last_pos_q;
            sym_d.neg = last_pos_q;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bit_q <= '0;
            for (int i = 0; i < ES; i++) begin
                flag_q[i] <= hcd_pkg::HCD_FL_NONE;
            end
        end else if (enc_step) begin
            bit_q <= {bit_q[ES-2:0], nrz_q};
            if (sub) begin
                for (int i = 0; i < ES - 1; i++) begin
                    flag_q[i+1] <= hcd_pkg::HCD_FL_SUB;
                end
                flag_q[0] <= hcd_pkg::HCD_FL_VIOL;
            end else begin
                for (int i = 0; i < ES - 1; i++) begin
                    flag_q[i+1] <= flag_q[i];
                end
                flag_q[0] <= hcd_pkg::HCD_FL_NONE;
            end
        end
    end

    // Odd mark count since the last violation means the run needs no balancing mark.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            last_pos_q <= 1'b0;
            odd_q      <= 1'b0;
        end else if (enc_step) begin
            if (lead_flag == hcd_pkg::HCD_FL_VIOL) begin
                odd_q <= 1'b0;
            end else if (sym_d.pos | sym_d.neg) begin
                last_pos_q <= ~last_pos_q;
                odd_q      <= ~odd_q;
            end
        end
    end

    hcd_skid_buf #(
        .W     (`HCD_BUF_W),
        .DEPTH (`HCD_BUF_DEPTH)
    ) u_sym_buf (
        .clk_in        (clk_in),
        .reset_n_in    (reset_n_in),
        .in_valid_in   (enc_fall),
        .in_ready_out  (buf_ready),
        .in_data_in    (sym_d),
        .out_valid_out (buf_valid),
        .out_ready_in  (enc_rise),
        .out_data_out  (sym_buf)
    );

    // Rails are high only for the high phase of the encode clock.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_pos_rail_out <= 1'b0;
            tx_neg_rail_out <= 1'b0;
        end else if (enc_rise) begin
            tx_pos_rail_out <= buf_valid & sym_buf.pos;
            tx_neg_rail_out <= buf_valid & sym_buf.neg;
        end else if (enc_fall) begin
            tx_pos_rail_out <= 1'b0;
            tx_neg_rail_out <= 1'b0;
        end
    end

    // Decoder.
    logic                  dec_now_q;
    logic                  dec_old_q;
    logic                  rx_pos_q;
    logic                  rx_neg_q;
    logic                  dec_rise;
    logic                  mark;
    logic                  same_pol;
    logic                  viol;
    logic [DS-1:0]         dbit_q;
    logic                  rx_last_pos_q;
    logic                  seen_q;
    logic [`HCD_RUN_W-1:0] run_q;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dec_now_q <= 1'b0;
            dec_old_q <= 1'b0;
            rx_pos_q  <= 1'b0;
            rx_neg_q  <= 1'b0;
        end else begin
            dec_now_q <= dec_clk_in;
            dec_old_q <= dec_now_q;
            rx_pos_q  <= rx_pos_rail_in;
            rx_neg_q  <= rx_neg_rail_in;
        end
    end

    assign dec_rise = dec_now_q & ~dec_old_q;
    // Both rails high is not a legal symbol and is read as a space.
    assign mark     = rx_pos_q ^ rx_neg_q;
    assign same_pol = mark & seen_q & (rx_pos_q == rx_last_pos_q);
    assign viol     = hdb3_q & same_pol;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dbit_q        <= '0;
            nrz_data_out  <= 1'b0;
            rx_last_pos_q <= 1'b0;
            seen_q        <= 1'b0;
        end else if (dec_rise) begin
            // A violation cancels itself and a balancing mark three places back.
            dbit_q       <= {dbit_q[DS-2:0], mark & ~viol};
            nrz_data_out <= dbit_q[DS-1] & ~viol;
            if (mark) begin
                rx_last_pos_q <= rx_pos_q;
                seen_q        <= 1'b1;
            end
        end
    end

    // Error is a pulse one decode period long.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_q     <= '0;
            error_out <= 1'b0;
        end else if (dec_rise) begin
            if (mark) begin
                run_q <= (same_pol && run_q != `HCD_RUN_ERR) ? `HCD_RUN_W'(run_q + 1'b1)
                       : (same_pol ? run_q : `HCD_RUN_ONE);
            end
            error_out <= hdb3_q & same_pol & (run_q == `HCD_RUN_ERR);
        end
    end
endmodule

// ===== testbench/hcd_line_codec_asserts.sv
// Port-level checks for the line codec.
module hcd_line_codec_asserts (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic code_select_in,
    input wire logic enc_clk_in,
    input wire logic dec_clk_in,
    input wire logic tx_pos_rail_out,
    input wire logic tx_neg_rail_out,
    input wire logic nrz_data_out,
    input wire logic error_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // Five low samples of the encode clock, four of the decode clock, outlast the two-cycle sampling lag of the clock pins.
    sequence s_enc_low; !enc_clk_in [*5]; endsequence
    sequence s_dec_low; !dec_clk_in [*4]; endsequence
    sequence s_rail_rise; $rose(tx_pos_rail_out || tx_neg_rail_out); endsequence
    a_rails_exclusive: assert property (!(tx_pos_rail_out && tx_neg_rail_out))
        else $error("both rails high");
    a_rails_rz: assert property (s_enc_low |-> !tx_pos_rail_out && !tx_neg_rail_out)
        else $error("rail high in low phase");
    a_launch_high: assert property (s_rail_rise |-> enc_clk_in && $past(enc_clk_in))
        else $error("rail launched off the high phase");
    a_pos_width: assert property ($rose(tx_pos_rail_out) |-> tx_pos_rail_out [*3])
        else $error("short positive pulse");
    a_neg_width: assert property ($rose(tx_neg_rail_out) |-> tx_neg_rail_out [*3])
        else $error("short negative pulse");
    a_nrz_on_rise: assert property (s_dec_low |=> $stable(nrz_data_out))
        else $error("data changed in decode low phase");
    a_err_on_rise: assert property (s_dec_low |=> $stable(error_out))
        else $error("error changed in decode low phase");
    a_err_holds: assert property ($rose(error_out) |-> error_out [*3])
        else $error("error pulse too short");
    a_ami_no_err: assert property ($rose(error_out) |-> $past(code_select_in, 2))
        else $error("error raised in plain mode");
endmodule

bind hcd_line_codec hcd_line_codec_asserts u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .code_select_in(code_select_in), .enc_clk_in(enc_clk_in), .dec_clk_in(dec_clk_in),
    .tx_pos_rail_out(tx_pos_rail_out), .tx_neg_rail_out(tx_neg_rail_out), .nrz_data_out(nrz_data_out),
    .error_out(error_out));

// ===== testbench/hcd_line_partner.sv
// Line transceiver model: logs sent symbols and plays back received ones.
module hcd_line_partner (
    input  wire logic enc_clk_in,
    input  wire logic tx_pos_rail_in,
    input  wire logic tx_neg_rail_in,
    input  wire logic dec_clk_in,
    input  wire logic swap_in,
    output logic      rx_pos_rail_out,
    output logic      rx_neg_rail_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] tx_log[$];
    logic [1:0] rx_q[$];
    logic [1:0] sym;
    initial {rx_pos_rail_out, rx_neg_rail_out} = 2'h0;
    // Rails are still high at the falling edge, so the mark is read there.
    always @(negedge enc_clk_in) tx_log.push_back({tx_pos_rail_in, tx_neg_rail_in});
    // An empty queue sends spaces, the idle state of the line.
    always @(negedge dec_clk_in) begin
        sym = (rx_q.size() > 0) ? rx_q.pop_front() : 2'h0;
        {rx_pos_rail_out, rx_neg_rail_out} <= swap_in ? {sym[0], sym[1]} : sym;
    end
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the line codec.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_in = 1'b0;
    logic       reset_n = 1'b0;
    logic       code_sel = 1'b1;
    logic       enc_clk = 1'b0;
    logic       nrz_in = 1'b0;
    logic       dec_clk = 1'b0;
    logic       swap = 1'b0;
    logic       tx_pos, tx_neg, rx_pos, rx_neg, nrz_out, err;
    logic [1:0] exp_sym[23];
    int         failures = 0;
    int         n_compared = 0;
    hcd_line_codec dut (.clk_in(clk_in), .reset_n_in(reset_n), .code_select_in(code_sel), .enc_clk_in(enc_clk),
        .nrz_data_in(nrz_in), .tx_pos_rail_out(tx_pos), .tx_neg_rail_out(tx_neg), .dec_clk_in(dec_clk),
        .rx_pos_rail_in(rx_pos), .rx_neg_rail_in(rx_neg), .nrz_data_out(nrz_out), .error_out(err));
    hcd_line_partner u_line (.enc_clk_in(enc_clk), .tx_pos_rail_in(tx_pos), .tx_neg_rail_in(tx_neg),
        .dec_clk_in(dec_clk), .swap_in(swap), .rx_pos_rail_out(rx_pos), .rx_neg_rail_out(rx_neg));
    initial forever #5 clk_in = ~clk_in;
    task automatic tick(int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic chk(string what, logic [1:0] exp, logic [1:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic restart(logic hdb, logic swp);
        reset_n = 1'b0;
        enc_clk = 1'b0;
        dec_clk = 1'b0;
        code_sel = hdb;
        swap = swp;
        u_line.tx_log.delete();
        u_line.rx_q.delete();
        tick(8);
        reset_n = 1'b1;
        tick(2);
    endtask
    // Symbol {pos,neg} per bit; the first mark after reset is positive.
    // The three zeros held in the encoder pipeline at reset go out ahead of the data,
    // so the line stream is those zeros followed by the twenty data bits.
    function automatic void code_line(logic hdb, logic [22:0] b);
        int   cnt;
        logic neg;
        cnt = 0;
        neg = 1'b1;
        for (int i = 0; i < 23; i++) begin
            if (b[i]) begin
                neg = !neg;
                cnt++;
                exp_sym[i] = neg ? 2'h1 : 2'h2;
            end else if (hdb && i < 20 && b[i+:4] == 4'h0) begin
                exp_sym[i] = (cnt % 2 == 0) ? (neg ? 2'h2 : 2'h1) : 2'h0;
                if (cnt % 2 == 0) neg = !neg;
                exp_sym[i+1] = 2'h0;
                exp_sym[i+2] = 2'h0;
                exp_sym[i+3] = neg ? 2'h1 : 2'h2;
                cnt = 0;
                i += 3;
            end else exp_sym[i] = 2'h0;
        end
    endfunction
    task automatic run_enc(logic [19:0] b);
        for (int k = 0; k < 24; k++) begin
            enc_clk = 1'b1;
            nrz_in = (k < 20) ? b[k] : 1'b1;
            tick(5);
            enc_clk = 1'b0;
            tick(5);
        end
        for (int k = 0; k < 23; k++) chk("tx symbol", exp_sym[k], u_line.tx_log[k+1]);
    endtask
    task automatic run_dec(logic [22:0] b, logic chk_bits, int err_at);
        foreach (exp_sym[j]) u_line.rx_q.push_back(exp_sym[j]);
        for (int m = 0; m < 27; m++) begin
            dec_clk = 1'b1;
            tick(6);
            if (chk_bits && m >= 4) chk("nrz out", {1'b0, b[m-4]}, {1'b0, nrz_out});
            chk("error", {1'b0, m == err_at + 1}, {1'b0, err});
            dec_clk = 1'b0;
            tick(5);
        end
    endtask
    // Runs of zeros after both odd and even mark counts, both directions at once.
    task automatic sc_hdb3_both();
        code_line(1'b1, {20'h80610, 3'h0});
        restart(1'b1, 1'b0);
        fork
            run_enc(20'h80610);
            run_dec({20'h80610, 3'h0}, 1'b1, -10);
        join
    endtask
    task automatic sc_ami_both();
        code_line(1'b0, {20'h80610, 3'h0});
        restart(1'b0, 1'b1);
        fork
            run_enc(20'h80610);
            run_dec({20'h80610, 3'h0}, 1'b1, -10);
        join
    endtask
    task automatic sc_law_error();
        foreach (exp_sym[j]) exp_sym[j] = (j < 5 && j % 2 == 0) ? 2'h2 : 2'h0;
        restart(1'b1, 1'b1);
        run_dec(23'h00015, 1'b0, 4);
        restart(1'b0, 1'b0);
        run_dec(23'h00015, 1'b1, -10);
    endtask
    initial begin
        sc_hdb3_both();
        sc_ami_both();
        sc_law_error();
        give_verdict();
    end
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
endmodule
